// ===== pps_pkg.sv
/*
  Shared constants and carrier types for the PCI port setup and
  concurrent read block. Assumes a single 100 MHz system clock.
*/
`default_nettype none
package pps_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CSR_OFS   = 8'h00;
  localparam logic [7:0] P1_CSR_OFS    = 8'h04;
  localparam logic [7:0] P2_CSR_OFS    = 8'h08;
  localparam logic [7:0] ARB_CTRL_OFS  = 8'h0C;
  localparam logic [7:0] READ_STAT_OFS = 8'h10;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int PRI_BIT      = 0;
  localparam int R64_BIT      = 1;
  localparam int NARROW_BIT   = 2;
  localparam int FAST1_BIT    = 3;
  localparam int FAST2_BIT    = 4;
  localparam int CAPABLE_BIT  = 21;
  localparam int HI2_POS      = 8;
  localparam int SHARED_POS   = 16;
  localparam int PARK_POS     = 20;
  localparam logic [31:0] ARB_CTRL_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int OWN_REQ  = 4;
  localparam int SH_REQ   = 3;
  localparam int ALL_REQ  = OWN_REQ + SH_REQ;
  localparam int SLOTS    = 2;
  localparam int DIRS     = 2;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic [2:0]  master;
  } pps_rd_req_t;

  typedef struct packed {
    logic        done;
    logic        retry;
    logic [31:0] data;
  } pps_rd_rsp_t;

  typedef struct packed {
    logic        valid;
    logic        slot;
    logic [31:0] addr;
  } pps_fetch_t;

  typedef struct packed {
    logic        valid;
    logic        slot;
    logic [31:0] data;
  } pps_fill_t;

  typedef struct packed {
    logic hot_swap;
    logic msg_unit;
    logic vpd;
  } pps_feat_t;

endpackage
`default_nettype wire

// ===== pps_top.sv
/*
  PCI port setup: power-up option capture, primary port choice, port 1
  width handling, two PCI arbiters and the concurrent read tracker,
  with an AHB-Lite register slave. Assumes PCI pins and PCI clocks are
  asynchronous to ref_clk_i and that read/fill ports come from logic
  on ref_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none

module pps_top
  import pps_pkg::*;
#(
  parameter bit SINGLE_PORT = 1'b0
) (
  // clock and reset
  input  wire logic                  ref_clk_i,
  input  wire logic                  arst_n_i,
  // ahb-lite slave
  input  wire logic                  hsel_i,
  input  wire logic [7:0]            haddr_i,
  input  wire logic [1:0]            htrans_i,
  input  wire logic                  hwrite_i,
  input  wire logic [2:0]            hsize_i,
  input  wire logic [31:0]           hwdata_i,
  input  wire logic                  hready_i,
  output logic                       hreadyout_o,
  output logic                       hresp_o,
  output logic [31:0]                hrdata_o,
  // power-up straps and pins
  input  wire logic                  primary_select_strap_i,
  input  wire logic                  port1_wide_request_strap_i,
  input  wire logic                  hot_swap_strap_i,
  input  wire logic                  port1_fast_clock_enable_i,
  input  wire logic                  port2_fast_clock_enable_i,
  input  wire logic                  port1_wide_enable_n_i,
  input  wire logic                  port1_bus_rst_n_i,
  // port 1 wide request pin
  input  wire logic                  port1_wide_request_n_i,
  output logic                       port1_wide_request_n_o,
  output logic                       port1_wide_request_n_oe,
  output logic                       port1_upper_drive_low_o,
  output logic                       port1_narrow_o,
  // port status
  output logic [1:0]                 port_fast_o,
  output pps_feat_t [1:0]            port_feat_o,
  // pci clocks and arbiters
  input  wire logic [1:0]            pci_clk_i,
  input  wire logic [1:0][ALL_REQ-1:0] pci_req_n_i,
  output logic [1:0][ALL_REQ-1:0]    pci_gnt_n_o,
  // concurrent reads, per direction
  input  wire pps_rd_req_t [DIRS-1:0] rd_req_i,
  output pps_rd_rsp_t [DIRS-1:0]     rd_rsp_o,
  output pps_fetch_t [DIRS-1:0]      fetch_o,
  input  wire pps_fill_t [DIRS-1:0]  fill_i
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  localparam int NSYNC = 10;
  localparam logic [NSYNC-1:0] SYNC_IDLE = 10'h0E0; // pins at idle level: no false edge after reset
  logic [NSYNC-1:0] pin_meta_reg;
  logic [NSYNC-1:0] pin_sync_reg;
  wire  [NSYNC-1:0] pin_raw = {pci_clk_i, port1_wide_request_n_i,
    port1_bus_rst_n_i, port1_wide_enable_n_i, port2_fast_clock_enable_i,
    port1_fast_clock_enable_i, hot_swap_strap_i,
    port1_wide_request_strap_i, primary_select_strap_i};

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_meta_reg <= SYNC_IDLE;
      pin_sync_reg <= SYNC_IDLE;
    end else begin
      pin_meta_reg <= pin_raw;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  wire s_pri     = pin_sync_reg[0];
  wire s_r64     = pin_sync_reg[1];
  wire s_hs      = pin_sync_reg[2];
  wire s_fast1   = pin_sync_reg[3];
  wire s_fast2   = pin_sync_reg[4];
  wire s_en_n    = pin_sync_reg[5];
  wire s_rst_n   = pin_sync_reg[6];
  wire s_req64_n = pin_sync_reg[7];
  wire [1:0] s_pclk = pin_sync_reg[8 +: 2];

  // ----------------------------------------------------------------
  // power-up option capture
  // ----------------------------------------------------------------
  // taken on the third clock after reset release, then frozen
  logic [2:0] cfg_wait_reg;
  logic       cfg_done_reg;
  logic       pri_reg;
  logic       r64_reg;
  logic       hs_reg;
  logic [1:0] fast_reg;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_wait_reg <= '0;
      cfg_done_reg <= 1'b0;
      pri_reg      <= 1'b0;
      r64_reg      <= 1'b0;
      hs_reg       <= 1'b0;
      fast_reg     <= '0;
    end else if (!cfg_done_reg) begin
      cfg_wait_reg <= cfg_wait_reg + 3'h1;
      if (cfg_wait_reg == 3'h2) begin
        cfg_done_reg <= 1'b1;
        pri_reg      <= SINGLE_PORT ? 1'b0 : s_pri;
        r64_reg      <= s_r64;
        hs_reg       <= s_hs;
        fast_reg     <= {s_fast2, s_fast1};
      end
    end
  end

  // ----------------------------------------------------------------
  // port 1 width
  // ----------------------------------------------------------------
  logic rst_seen_reg;
  logic req_smp_reg;
  logic narrow_reg;
  logic req_oe_reg;
  logic upper_low_reg;
  logic [1:0] fast_out_reg;
  pps_feat_t [1:0] feat_reg;

  wire  rst_rise   = s_rst_n & ~rst_seen_reg;
  // enable pin low with strap: device itself announces 64 bits
  wire  drive_req  = r64_reg & ~s_en_n & ~s_rst_n & cfg_done_reg;
  wire  narrow_nxt = hs_reg ? s_en_n : (req_smp_reg & s_en_n);

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_seen_reg <= 1'b1;
      req_smp_reg  <= 1'b1;
    end else begin
      rst_seen_reg <= s_rst_n;
      if (rst_rise) begin
        req_smp_reg <= s_req64_n;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      narrow_reg    <= 1'b0;
      req_oe_reg    <= 1'b0;
      upper_low_reg <= 1'b0;
      fast_out_reg  <= '0;
      feat_reg      <= '0;
    end else begin
      narrow_reg    <= narrow_nxt;
      upper_low_reg <= narrow_nxt & s_rst_n & cfg_done_reg;
      req_oe_reg    <= drive_req | (narrow_nxt & s_rst_n & cfg_done_reg);
      fast_out_reg  <= fast_reg;
      feat_reg[0]   <= {3{cfg_done_reg & ~pri_reg}};
      feat_reg[1]   <= {3{cfg_done_reg & pri_reg & ~SINGLE_PORT}};
    end
  end

  assign port1_wide_request_n_o  = 1'b0;
  assign port1_wide_request_n_oe = req_oe_reg;
  assign port1_upper_drive_low_o = upper_low_reg;
  assign port1_narrow_o          = narrow_reg;
  assign port_fast_o             = fast_out_reg;
  assign port_feat_o             = feat_reg;

  // ----------------------------------------------------------------
  // ahb-lite register slave
  // ----------------------------------------------------------------
  logic [31:0] arb_ctrl_reg;
  logic        wr_pend_reg;
  logic [7:0]  wr_addr_reg;
  logic [31:0] rdata_reg;
  logic        hready_reg;
  logic [7:0]  rd_stat;

  wire addr_ok = hsel_i & hready_i & (htrans_i == HTRANS_NONSEQ);
  wire [31:0] rst_csr = {27'h0, fast_reg[1], fast_reg[0], narrow_reg,
                         r64_reg, pri_reg};
  wire [31:0] cap_csr = 32'h1 << CAPABLE_BIT;
  wire [31:0] rd_mux  =
    (haddr_i == RST_CSR_OFS)   ? rst_csr :
    (haddr_i == P1_CSR_OFS)    ? cap_csr :
    (haddr_i == P2_CSR_OFS)    ? (SINGLE_PORT ? 32'h0 : cap_csr) :
    (haddr_i == ARB_CTRL_OFS)  ? arb_ctrl_reg :
    (haddr_i == READ_STAT_OFS) ? {24'h0, rd_stat} : 32'h0;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
      rdata_reg   <= '0;
      hready_reg  <= 1'b1;
    end else begin
      wr_pend_reg <= addr_ok & hwrite_i;
      wr_addr_reg <= haddr_i;
      rdata_reg   <= (addr_ok & ~hwrite_i) ? rd_mux : 32'h0;
      hready_reg  <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      arb_ctrl_reg <= ARB_CTRL_RST;
    end else if (wr_pend_reg && wr_addr_reg == ARB_CTRL_OFS) begin
      arb_ctrl_reg <= hwdata_i;
    end
  end

  assign hreadyout_o = hready_reg;
  assign hresp_o     = 1'b0;
  assign hrdata_o    = rdata_reg;

  // ----------------------------------------------------------------
  // pci arbiters, stepped on sampled pci clock edges
  // ----------------------------------------------------------------
  function automatic logic [ALL_REQ-1:0] rr_pick(
    input logic [ALL_REQ-1:0] req,
    input logic [2:0]         last
  );
    logic [ALL_REQ-1:0] g;
    int unsigned        idx;
    g = '0;
    for (int k = ALL_REQ; k >= 1; k--) begin
      idx = (32'(last) + k) % ALL_REQ;
      if (req[idx]) begin
        g = '0;
        g[idx] = 1'b1;
      end
    end
    return g;
  endfunction

  function automatic logic [2:0] enc(input logic [ALL_REQ-1:0] g);
    logic [2:0] e;
    e = '0;
    for (int k = 0; k < ALL_REQ; k++) begin
      if (g[k]) begin
        e = 3'(k);
      end
    end
    return e;
  endfunction

  logic [1:0] pclk_d_reg;
  logic [1:0][ALL_REQ-1:0] req_m_reg;
  logic [1:0][ALL_REQ-1:0] req_s_reg;
  logic [1:0][ALL_REQ-1:0] gnt_reg;
  logic [1:0][2:0]         last_reg;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pclk_d_reg <= '0;
      req_m_reg  <= '0;
      req_s_reg  <= '0;
    end else begin
      pclk_d_reg <= s_pclk;
      req_m_reg  <= ~pci_req_n_i;
      req_s_reg  <= req_m_reg;
    end
  end

  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_arb
      wire [SH_REQ-1:0] sh_own = p ? arb_ctrl_reg[SHARED_POS +: SH_REQ]
                                   : ~arb_ctrl_reg[SHARED_POS +: SH_REQ];
      wire [ALL_REQ-1:0] elig  = req_s_reg[p] & {sh_own, {OWN_REQ{1'b1}}};
      wire [ALL_REQ-1:0] hi    = elig & arb_ctrl_reg[p*HI2_POS +: ALL_REQ];
      wire [ALL_REQ-1:0] pick  = (|hi) ? rr_pick(hi, last_reg[p])
                                       : rr_pick(elig, last_reg[p]);
      wire               park_fixed = arb_ctrl_reg[PARK_POS + p];
      wire [ALL_REQ-1:0] idle  = park_fixed ? ALL_REQ'(1) : gnt_reg[p];
      wire               edge_p = s_pclk[p] & ~pclk_d_reg[p];
      wire               live  = (p == 0) | ~SINGLE_PORT;

      always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          gnt_reg[p]  <= '0;
          last_reg[p] <= '0;
        end else if (edge_p && live && cfg_done_reg) begin
          gnt_reg[p] <= (|elig) ? pick : idle;
          if (|elig) begin
            last_reg[p] <= enc(pick);
          end
        end
      end
      assign pci_gnt_n_o[p] = ~gnt_reg[p];
    end
  endgenerate

  // ----------------------------------------------------------------
  // concurrent read tracker, two slots per direction
  // ----------------------------------------------------------------
  // config reads from the host use the same slots as plain reads: the
  // cycle type travels with the fetch address on the far side
  genvar d;
  generate
    for (d = 0; d < DIRS; d++) begin : g_rd
      logic [SLOTS-1:0]       busy_reg;
      logic [SLOTS-1:0]       ready_reg;
      logic [SLOTS-1:0][31:0] addr_reg;
      logic [SLOTS-1:0][2:0]  mst_reg;
      logic [SLOTS-1:0][31:0] data_reg;
      pps_rd_rsp_t            rsp_reg;
      pps_fetch_t             fetch_reg;

      wire pps_rd_req_t q = rd_req_i[d];
      wire pps_fill_t   f = fill_i[d];
      wire hit0 = busy_reg[0] & (addr_reg[0] == q.addr) & (mst_reg[0] == q.master);
      wire hit1 = busy_reg[1] & (addr_reg[1] == q.addr) & (mst_reg[1] == q.master);
      wire hs   = hit1;
      wire hit  = hit0 | hit1;
      wire fs   = busy_reg[0];
      wire free = ~&busy_reg;

      always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          busy_reg  <= '0;
          ready_reg <= '0;
          addr_reg  <= '0;
          mst_reg   <= '0;
          data_reg  <= '0;
          rsp_reg   <= '0;
          fetch_reg <= '0;
        end else begin
          rsp_reg   <= '0;
          fetch_reg <= '0;
          if (f.valid && busy_reg[f.slot]) begin
            ready_reg[f.slot] <= 1'b1;
            data_reg[f.slot]  <= f.data;
          end
          if (q.valid) begin
            if (hit && ready_reg[hs]) begin
              rsp_reg.done  <= 1'b1;
              rsp_reg.data  <= data_reg[hs];
              busy_reg[hs]  <= 1'b0;
              ready_reg[hs] <= 1'b0;
            end else if (hit) begin
              rsp_reg.retry <= 1'b1;
            end else if (free) begin
              rsp_reg.retry   <= 1'b1;
              busy_reg[fs]    <= 1'b1;
              addr_reg[fs]    <= q.addr;
              mst_reg[fs]     <= q.master;
              fetch_reg.valid <= 1'b1;
              fetch_reg.slot  <= fs;
              fetch_reg.addr  <= q.addr;
            end else begin
              rsp_reg.retry <= 1'b1;
            end
          end
        end
      end

      assign rd_rsp_o[d]         = rsp_reg;
      assign fetch_o[d]          = fetch_reg;
      assign rd_stat[d*2 +: 2]   = busy_reg;
      assign rd_stat[4+d*2 +: 2] = ready_reg;
    end
  endgenerate

endmodule
`default_nettype wire

// ===== pps_monitor.sv
/*
  Checker for pps_top: sees only its ports, bound in below.
  Assumes one clock domain, ref_clk_i with arst_n_i.
*/
`timescale 1ns/1ps
`default_nettype none
module pps_monitor
  import pps_pkg::*;
(
  // clock and reset
  input wire logic                      ref_clk_i,
  input wire logic                      arst_n_i,
  // watched ports
  input wire logic                      hreadyout_o,
  input wire logic                      hresp_o,
  input wire pps_rd_req_t [DIRS-1:0]    rd_req_i,
  input wire pps_rd_rsp_t [DIRS-1:0]    rd_rsp_o,
  input wire pps_fetch_t [DIRS-1:0]     fetch_o,
  input wire logic                      port1_upper_drive_low_o,
  input wire logic                      port1_narrow_o,
  input wire pps_feat_t [1:0]           port_feat_o,
  input wire logic                      port1_wide_request_n_oe,
  input wire logic                      port1_wide_enable_n_i,
  input wire logic                      port1_bus_rst_n_i,
  input wire logic [1:0][ALL_REQ-1:0]   pci_gnt_n_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);

  bus_okay_a: assert property (hreadyout_o && !hresp_o) else $error("ahb not ready or error");
  rsp_once_a: assert property (rd_req_i[0].valid |=> rd_rsp_o[0].done != rd_rsp_o[0].retry)
    else $error("read request without single answer");
  rsp_once1_a: assert property (rd_req_i[1].valid |=> rd_rsp_o[1].done != rd_rsp_o[1].retry)
    else $error("read request without single answer");
  rsp_cause_a: assert property ((rd_rsp_o[0].done || rd_rsp_o[0].retry) |-> $past(rd_req_i[0].valid))
    else $error("answer without request");
  fetch_cause_a: assert property (fetch_o[0].valid |-> $past(rd_req_i[0].valid) && rd_rsp_o[0].retry
    && fetch_o[0].addr == $past(rd_req_i[0].addr)) else $error("fetch not from retried request");
  narrow_drive_a: assert property (port1_upper_drive_low_o |-> port1_narrow_o)
    else $error("upper lines driven while wide");
  feat_group_a: assert property ((port_feat_o[0] inside {3'h0, 3'h7}) && (port_feat_o[1] inside {3'h0, 3'h7})
    && $onehot0({port_feat_o[0].vpd, port_feat_o[1].vpd})) else $error("extra features split");
  feat_hold_a: assert property (port_feat_o != $past(port_feat_o) |-> $past(port_feat_o) == '0)
    else $error("primary choice changed in run");
  req_drive_a: assert property ($rose(port1_wide_request_n_oe) && !port1_upper_drive_low_o
    |-> !$past(port1_wide_enable_n_i, 2) && !$past(port1_bus_rst_n_i, 2))
    else $error("wide request driven unpermitted");
  gnt_one_a: assert property ($onehot0(~pci_gnt_n_o[0]) && $onehot0(~pci_gnt_n_o[1]))
    else $error("more than one grant");

  cover property (rd_rsp_o[0].retry && fetch_o[0].valid);
  cover property (rd_rsp_o[1].done);
  cover property ($rose(port1_wide_request_n_oe));
endmodule

bind pps_top pps_monitor mon (
  .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
  .rd_req_i(rd_req_i), .rd_rsp_o(rd_rsp_o), .fetch_o(fetch_o),
  .port1_upper_drive_low_o(port1_upper_drive_low_o), .port1_narrow_o(port1_narrow_o),
  .port_feat_o(port_feat_o), .port1_wide_request_n_oe(port1_wide_request_n_oe),
  .port1_wide_enable_n_i(port1_wide_enable_n_i), .port1_bus_rst_n_i(port1_bus_rst_n_i),
  .pci_gnt_n_o(pci_gnt_n_o));
`default_nettype wire

// ===== pps_far_model.sv
/*
  Destination bus model: answers each fetch with one fill after a
  set delay. Assumes fetches to the two slots do not expire together.
*/
`timescale 1ns/1ps
`default_nettype none
module pps_far_model
  import pps_pkg::*;
#(
  parameter logic [31:0] FILL_MASK = 32'h5A5A_0000
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // fetch in, fill out
  input  wire pps_fetch_t fetch_i,
  input  wire logic [7:0] delay_i,
  output pps_fill_t       fill_o
);
  logic [7:0]  wait_reg [SLOTS];
  logic [31:0] addr_reg [SLOTS];

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_reg <= '{default: 8'h00};
      fill_o   <= '0;
    end else begin
      // idle data keeps toggling so stale values never look valid
      fill_o.valid <= 1'b0;
      fill_o.data  <= ~fill_o.data;
      for (int s = 0; s < SLOTS; s++) begin
        if (wait_reg[s] == 8'h01) begin
          fill_o <= '{valid: 1'b1, slot: 1'(s), data: addr_reg[s] ^ FILL_MASK};
        end
        if (wait_reg[s] != 8'h00) begin
          wait_reg[s] <= wait_reg[s] - 8'h01;
        end
      end
      if (fetch_i.valid) begin
        wait_reg[fetch_i.slot] <= delay_i;
        addr_reg[fetch_i.slot] <= fetch_i.addr;
      end
    end
  end
endmodule
`default_nettype wire

// ===== test_pps_top.sv
/*
  Self-checking bench for pps_top with two destination bus models.
  Assumes zero-wait AHB-Lite and free-running 160 ns PCI clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module test_pps_top
  import pps_pkg::*;
;
  localparam logic [31:0] MASK = 32'h5A5A_0000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pclk0 = 1'b0;
  logic pclk1 = 1'b0;
  logic hsel, hwrite, hrdy, hresp;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [31:0] hwdata, hrdata;
  logic pri_s, r64_s, f1_s, f2_s, hs_s, en_n, brst_n, req64_pin, oe, req64_o, upper, narrow;
  wire logic req64_w;
  logic [1:0] fast;
  pps_feat_t [1:0] feat;
  logic [1:0][ALL_REQ-1:0] preq, pgnt;
  pps_rd_req_t [DIRS-1:0] rq;
  pps_rd_rsp_t [DIRS-1:0] rsp;
  pps_fetch_t [DIRS-1:0] fet;
  pps_fill_t fill0, fill1;
  pps_fill_t [DIRS-1:0] fill;
  int bad_count = 0;
  int checked = 0;

  // bench-set level on the wide request pin when the device does not drive it
  assign req64_w = oe ? req64_o : req64_pin;
  assign fill = {fill1, fill0};

  always #5 clk = ~clk;
  always #80 pclk0 = ~pclk0;
  initial begin
    #37;
    forever #80 pclk1 = ~pclk1;
  end

  pps_top dut (
    .ref_clk_i(clk), .arst_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy), .hreadyout_o(hrdy),
    .hresp_o(hresp), .hrdata_o(hrdata), .primary_select_strap_i(pri_s),
    .port1_wide_request_strap_i(r64_s), .hot_swap_strap_i(hs_s), .port1_fast_clock_enable_i(f1_s),
    .port2_fast_clock_enable_i(f2_s), .port1_wide_enable_n_i(en_n), .port1_bus_rst_n_i(brst_n),
    .port1_wide_request_n_i(req64_w), .port1_wide_request_n_o(req64_o), .port1_wide_request_n_oe(oe),
    .port1_upper_drive_low_o(upper), .port1_narrow_o(narrow), .port_fast_o(fast), .port_feat_o(feat),
    .pci_clk_i({pclk1, pclk0}), .pci_req_n_i(preq), .pci_gnt_n_o(pgnt), .rd_req_i(rq),
    .rd_rsp_o(rsp), .fetch_o(fet), .fill_i(fill));
  pps_far_model #(.FILL_MASK(MASK)) far0 (.clk_i(clk), .rst_n_i(rst_n), .fetch_i(fet[0]),
    .delay_i(8'h1E), .fill_o(fill0));
  pps_far_model #(.FILL_MASK(MASK)) far1 (.clk_i(clk), .rst_n_i(rst_n), .fetch_i(fet[1]),
    .delay_i(8'h03), .fill_o(fill1));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask

  task rd(input int d, input logic [31:0] a, input logic [2:0] m, output pps_rd_rsp_t r,
          output pps_fetch_t f);
    @(posedge clk);
    rq[d] <= '{valid: 1'b1, addr: a, master: m};
    @(posedge clk);
    rq[d].valid <= 1'b0;
    #1;
    r = rsp[d];
    f = fet[d];
  endtask

  task wait_gnt(input int p, input int r);
    int i;
    for (i = 0; i < 300 && pgnt[p][r] !== 1'b0; i++) @(posedge clk);
    chk(pgnt[p][r], 1'b0);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_conc;
    logic [31:0] v;
    int d;
    pps_rd_rsp_t r;
    pps_fetch_t f;
    for (d = 0; d < DIRS; d++) begin
      rd(d, 32'h1000_0040, 3'h1, r, f);
      chk({r.retry, r.done, f.valid, f.slot, f.addr}, {4'b1010, 32'h1000_0040});
      rd(d, 32'h2000_0080, 3'h2, r, f);
      chk({r.retry, r.done, f.valid, f.slot, f.addr}, {4'b1011, 32'h2000_0080});
      rd(d, 32'h3000_00C0, 3'h3, r, f);
      chk({r.retry, r.done, f.valid}, 3'b100);
      if (d == 0) begin
        rd(d, 32'h1000_0040, 3'h1, r, f);
        chk({r.retry, r.done}, 2'b10);
      end
      // both models answer well inside this span
      repeat (40) @(posedge clk);
      ahb(1'b0, READ_STAT_OFS, 32'h0, v);
      chk(v, 32'h33 << (2 * d));
      rd(d, 32'h2000_0080, 3'h1, r, f);
      chk({r.retry, r.done}, 2'b10);
      rd(d, 32'h1000_0040, 3'h1, r, f);
      chk({r.retry, r.done, r.data}, {2'b01, 32'h1000_0040 ^ MASK});
      rd(d, 32'h2000_0080, 3'h2, r, f);
      chk({r.retry, r.done, r.data}, {2'b01, 32'h2000_0080 ^ MASK});
    end
  endtask

  task t_straps(input logic pri, input logic r64, input logic f1, input logic f2, input logic hs);
    logic [31:0] v;
    @(posedge clk);
    rst_n <= 1'b0;
    {pri_s, r64_s, f1_s, f2_s, hs_s} <= {pri, r64, f1, f2, hs};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk);
    ahb(1'b0, RST_CSR_OFS, 32'h0, v);
    chk(v & 32'hFFFF_FFFB, {27'h0, f2, f1, 1'b0, r64, pri});
    pri_s <= ~pri;
    f1_s <= ~f1;
    ahb(1'b1, RST_CSR_OFS, 32'hFFFF_FFFF, v);
    repeat (10) @(posedge clk);
    ahb(1'b0, RST_CSR_OFS, 32'h0, v);
    chk(v & 32'hFFFF_FFFB, {27'h0, f2, f1, 1'b0, r64, pri});
    chk({feat[pri], feat[~pri], fast}, {3'h7, 3'h0, f2, f1});
    ahb(1'b0, P1_CSR_OFS, 32'h0, v);
    chk(v[CAPABLE_BIT], 1'b1);
    ahb(1'b0, P2_CSR_OFS, 32'h0, v);
    chk(v[CAPABLE_BIT], 1'b1);
    ahb(1'b0, READ_STAT_OFS + 8'h04, 32'h0, v);
    chk(v, 32'h0);
    ahb(1'b0, ARB_CTRL_OFS, 32'h0, v);
    chk(v, ARB_CTRL_RST);
    // bus reset with the wide request pin low: only hot swap ignores it
    req64_pin <= 1'b0;
    brst_n <= 1'b0;
    repeat (8) @(posedge clk);
    brst_n <= 1'b1;
    repeat (8) @(posedge clk);
    chk(narrow, hs);
  endtask

  task t_width;
    int k;
    @(posedge clk);
    brst_n <= 1'b0;
    repeat (8) @(posedge clk);
    chk(oe, 1'b0);
    en_n <= 1'b0;
    repeat (8) @(posedge clk);
    chk({oe, req64_o}, 2'b10);
    en_n <= 1'b1;
    repeat (8) @(posedge clk);
    chk(oe, 1'b0);
    for (k = 0; k < 2; k++) begin
      req64_pin <= k[0];
      brst_n <= 1'b0;
      repeat (8) @(posedge clk);
      brst_n <= 1'b1;
      repeat (8) @(posedge clk);
      chk({narrow, upper}, {2{k[0]}});
    end
  endtask

  task t_arb;
    logic [31:0] v;
    int p;
    for (p = 0; p < 2; p++) begin
      @(posedge clk);
      preq[p] <= 7'h7E;
      wait_gnt(p, 0);
      preq[p] <= 7'h7F;
    end
    ahb(1'b1, ARB_CTRL_OFS, 32'h0001_0000, v);
    ahb(1'b0, ARB_CTRL_OFS, 32'h0, v);
    chk(v, 32'h0001_0000);
    @(posedge clk);
    preq[1] <= 7'h6F;
    wait_gnt(1, 4);
    preq[1] <= 7'h7F;
  endtask

  task print_verdict;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    {hsel, hwrite, haddr, htrans, hwdata} = '0;
    {pri_s, r64_s, f1_s, f2_s, hs_s, en_n, brst_n, req64_pin} = 8'h97;
    preq = '1;
    rq = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk);
    t_conc;
    t_straps(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    t_straps(1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    t_width;
    t_arb;
    print_verdict;
  end

  initial begin
    #200000;
    bad_count++;
    print_verdict;
  end
endmodule
`default_nettype wire
